// [logic/hbs_sequencer.sv]
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - The release delay after enable is programmable from 0 to 2000 ms and defaults to 10 ms.
// RL2 - On enable the motor is energized first and the brake stays applied until the delay ends.
// RL3 - On alarm with zero-speed stop the brake acts at once, while the motor is braked electrically to rest.
// RL4 - A speed threshold above the motor maximum speed is clamped to that maximum.
// RL5 - At disable while turning the brake acts on low speed or wait timeout, whichever is first.
// RL6 - On the single-tube variant a zero release delay still releases after about 20 ms.
module hbs_sequencer #(
  parameter int CYC_PER_MS = hbs_pkg::CYC_PER_MS,
  parameter logic [15:0] MOTOR_MAX_RPM = 16'h0bb8
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  // register port
  input wire hbs_pkg::hbs_bus_s I_BUS,
  output logic [15:0] O_RDATA,
  // drive status
  input wire logic I_SERVO_EN,
  input wire logic I_ALARM,
  input wire logic [15:0] I_MOTOR_RPM,
  // outputs
  output logic O_MOTOR_ENERGIZE,
  output logic O_ZERO_SPEED_CMD,
  output logic O_BRAKE_RELEASE
);
  logic [15:0] release_delay_q;
  logic [15:0] apply_delay_q;
  logic [15:0] wait_time_q;
  logic [15:0] speed_thresh_q;
  logic [1:0] ctrl_q;
  hbs_pkg::hbs_state_e state_q;
  logic [31:0] pre_q;
  logic ms_tick;
  logic [15:0] ms_cnt_q;
  logic [15:0] eff_thresh;
  logic [15:0] eff_release;
  logic slow;

  function automatic logic [15:0] clamp_ms(input logic [15:0] v);
    clamp_ms = (v > hbs_pkg::MAX_DELAY_MS) ? hbs_pkg::MAX_DELAY_MS : v;
  endfunction : clamp_ms

  // register writes
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      release_delay_q <= hbs_pkg::RST_RELEASE_DELAY;
      apply_delay_q <= hbs_pkg::RST_APPLY_DELAY;
      wait_time_q <= hbs_pkg::RST_WAIT_TIME;
      speed_thresh_q <= hbs_pkg::RST_SPEED_THRESH;
      ctrl_q <= 2'h0;
    end
    else if (I_BUS.wr)
    begin
      unique case (I_BUS.addr)
        hbs_pkg::ADDR_RELEASE_DELAY: release_delay_q <= clamp_ms(I_BUS.wdata); // RL1
        hbs_pkg::ADDR_APPLY_DELAY: apply_delay_q <= clamp_ms(I_BUS.wdata);
        hbs_pkg::ADDR_WAIT_TIME: wait_time_q <= clamp_ms(I_BUS.wdata);
        hbs_pkg::ADDR_SPEED_THRESH: speed_thresh_q <= I_BUS.wdata;
        hbs_pkg::ADDR_CTRL: ctrl_q <= I_BUS.wdata[1:0];
        default: ;
      endcase
    end
  end

  // register reads, one cycle later; unmapped reads zero
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      O_RDATA <= 16'h0000;
    else if (I_BUS.rd)
    begin
      unique case (I_BUS.addr)
        hbs_pkg::ADDR_RELEASE_DELAY: O_RDATA <= release_delay_q;
        hbs_pkg::ADDR_APPLY_DELAY: O_RDATA <= apply_delay_q;
        hbs_pkg::ADDR_WAIT_TIME: O_RDATA <= wait_time_q;
        hbs_pkg::ADDR_SPEED_THRESH: O_RDATA <= speed_thresh_q;
        hbs_pkg::ADDR_CTRL: O_RDATA <= {14'h0000, ctrl_q};
        hbs_pkg::ADDR_STATUS: O_RDATA <= {13'h0000, O_ZERO_SPEED_CMD,
          O_BRAKE_RELEASE, O_MOTOR_ENERGIZE};
        default: O_RDATA <= 16'h0000;
      endcase
    end
  end

  assign eff_thresh = (speed_thresh_q > MOTOR_MAX_RPM) ? MOTOR_MAX_RPM : speed_thresh_q; // RL4
  assign slow = I_MOTOR_RPM < eff_thresh;
  assign eff_release = (ctrl_q[hbs_pkg::CTRL_SINGLE_TUBE_BIT] && release_delay_q == 16'h0000)
    ? hbs_pkg::SINGLE_TUBE_MS : release_delay_q; // RL6

  // millisecond prescaler, restarted on each state change
  logic restart;
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      pre_q <= 32'h0;
    else if (restart || pre_q == 32'(CYC_PER_MS - 1))
      pre_q <= 32'h0;
    else
      pre_q <= pre_q + 32'h1;
  end
  assign ms_tick = !restart && pre_q == 32'(CYC_PER_MS - 1);

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      ms_cnt_q <= 16'h0;
    else if (restart)
      ms_cnt_q <= 16'h0;
    else if (ms_tick && ms_cnt_q != 16'hffff)
      ms_cnt_q <= ms_cnt_q + 16'h1;
  end

  hbs_pkg::hbs_state_e state_d;
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      hbs_pkg::ST_OFF:
        if (I_SERVO_EN && !I_ALARM)
          state_d = hbs_pkg::ST_RELEASE_WAIT; // RL2
      hbs_pkg::ST_RELEASE_WAIT:
        if (I_ALARM && ctrl_q[hbs_pkg::CTRL_ZS_STOP_BIT])
          state_d = hbs_pkg::ST_ZERO_SPEED;
        else if (!I_SERVO_EN || I_ALARM)
          state_d = hbs_pkg::ST_OFF;
        else if (ms_cnt_q >= eff_release)
          state_d = hbs_pkg::ST_RUN; // RL2
      hbs_pkg::ST_RUN:
        if (I_ALARM && ctrl_q[hbs_pkg::CTRL_ZS_STOP_BIT])
          state_d = hbs_pkg::ST_ZERO_SPEED; // RL3
        else if (!I_SERVO_EN || I_ALARM)
          state_d = slow ? hbs_pkg::ST_OFF : hbs_pkg::ST_STOP_WAIT; // RL5
      hbs_pkg::ST_ZERO_SPEED:
        if (slow)
          state_d = hbs_pkg::ST_APPLY_WAIT; // RL3
      hbs_pkg::ST_APPLY_WAIT:
        if (ms_cnt_q >= apply_delay_q)
          state_d = hbs_pkg::ST_OFF; // RL3
      hbs_pkg::ST_STOP_WAIT:
        if (slow || ms_cnt_q >= wait_time_q)
          state_d = hbs_pkg::ST_OFF; // RL5
    endcase
  end
  assign restart = state_d != state_q;

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      state_q <= hbs_pkg::ST_OFF;
    else
      state_q <= state_d;
  end

  // outputs registered from next state
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_MOTOR_ENERGIZE <= 1'b0;
      O_BRAKE_RELEASE <= 1'b0;
      O_ZERO_SPEED_CMD <= 1'b0;
    end
    else
    begin
      O_MOTOR_ENERGIZE <= state_d != hbs_pkg::ST_OFF; // RL2
      O_BRAKE_RELEASE <= state_d == hbs_pkg::ST_RUN || state_d == hbs_pkg::ST_STOP_WAIT; // RL5
      O_ZERO_SPEED_CMD <= state_d == hbs_pkg::ST_ZERO_SPEED ||
        state_d == hbs_pkg::ST_APPLY_WAIT; // RL3
    end
  end

  brake_before_energize_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL2
    O_BRAKE_RELEASE |-> O_MOTOR_ENERGIZE)
    else $error("brake released while motor not energized");

  release_timing_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL1
    $rose(O_BRAKE_RELEASE) |-> $past(state_q) == hbs_pkg::ST_RELEASE_WAIT &&
      $past(ms_cnt_q) >= $past(eff_release))
    else $error("brake released before delay");

  zero_speed_brake_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL3
    O_ZERO_SPEED_CMD |-> !O_BRAKE_RELEASE)
    else $error("brake released during zero speed stop");

  threshold_clamp_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL4
    eff_thresh <= MOTOR_MAX_RPM)
    else $error("threshold above motor maximum");

  stop_wait_end_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL5
    state_q == hbs_pkg::ST_STOP_WAIT && slow |=> !O_BRAKE_RELEASE)
    else $error("brake not applied at low speed");

  single_tube_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL6
    ctrl_q[hbs_pkg::CTRL_SINGLE_TUBE_BIT] && release_delay_q == 16'h0000 |->
      eff_release == hbs_pkg::SINGLE_TUBE_MS)
    else $error("single tube minimum delay missing");

  // outputs follow the state that was entered
  energize_first_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL2
    $rose(O_BRAKE_RELEASE) |-> $past(O_MOTOR_ENERGIZE))
    else $error("brake released without prior energize");

  alarm_refused_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL2
    state_q == hbs_pkg::ST_OFF && I_ALARM |=> !O_MOTOR_ENERGIZE)
    else $error("enable accepted during alarm");

  release_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL2
    state_q == hbs_pkg::ST_RELEASE_WAIT |-> O_MOTOR_ENERGIZE && !O_BRAKE_RELEASE)
    else $error("brake not held during release delay");

  run_outputs_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL2
    state_q == hbs_pkg::ST_RUN |-> O_MOTOR_ENERGIZE && O_BRAKE_RELEASE)
    else $error("run state outputs wrong");

  off_outputs_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL2
    state_q == hbs_pkg::ST_OFF |->
      !O_MOTOR_ENERGIZE && !O_BRAKE_RELEASE && !O_ZERO_SPEED_CMD)
    else $error("outputs active while off");

  delay_saturate_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL1
    release_delay_q <= hbs_pkg::MAX_DELAY_MS)
    else $error("release delay above range");

  write_release_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL1
    I_BUS.wr && I_BUS.addr == hbs_pkg::ADDR_RELEASE_DELAY |=>
      release_delay_q == clamp_ms($past(I_BUS.wdata)))
    else $error("release delay write lost");

  read_release_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL1
    $past(I_BUS.rd) && $past(I_BUS.addr) == hbs_pkg::ADDR_RELEASE_DELAY |->
      O_RDATA == $past(release_delay_q))
    else $error("release delay read wrong");

  prescaler_range_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL1
    pre_q < 32'(CYC_PER_MS))
    else $error("millisecond prescaler out of range");

  zs_from_alarm_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL3
    $rose(O_ZERO_SPEED_CMD) |-> $past(I_ALARM) && $past(ctrl_q[hbs_pkg::CTRL_ZS_STOP_BIT]))
    else $error("zero speed command without alarm");

  zs_brake_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL3
    state_q == hbs_pkg::ST_ZERO_SPEED && !slow |=>
      O_ZERO_SPEED_CMD && O_MOTOR_ENERGIZE && !O_BRAKE_RELEASE)
    else $error("zero speed stop left too early");

  apply_wait_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL3
    state_q == hbs_pkg::ST_APPLY_WAIT |->
      O_ZERO_SPEED_CMD && O_MOTOR_ENERGIZE && !O_BRAKE_RELEASE)
    else $error("apply wait outputs wrong");

  zs_exit_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL3
    state_q == hbs_pkg::ST_APPLY_WAIT && ms_cnt_q >= apply_delay_q |=>
      !O_ZERO_SPEED_CMD && !O_MOTOR_ENERGIZE)
    else $error("zero speed stop not ended after apply delay");

  effective_thresh_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL4
    speed_thresh_q <= MOTOR_MAX_RPM |-> eff_thresh == speed_thresh_q)
    else $error("threshold changed below motor maximum");

  slow_disable_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL5
    state_q == hbs_pkg::ST_RUN && !I_SERVO_EN && !I_ALARM && slow |=>
      !O_BRAKE_RELEASE && !O_MOTOR_ENERGIZE)
    else $error("brake late at slow disable");

  fast_disable_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL5
    state_q == hbs_pkg::ST_RUN && !I_SERVO_EN && !I_ALARM && !slow |=>
      O_BRAKE_RELEASE && O_MOTOR_ENERGIZE)
    else $error("brake applied while turning fast");

  alarm_plain_stop_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL5
    state_q == hbs_pkg::ST_RUN && I_ALARM && !ctrl_q[hbs_pkg::CTRL_ZS_STOP_BIT] && slow |=>
      !O_MOTOR_ENERGIZE)
    else $error("alarm stop kept motor energized");

  wait_timeout_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL5
    state_q == hbs_pkg::ST_STOP_WAIT && ms_cnt_q >= wait_time_q |=> !O_BRAKE_RELEASE)
    else $error("brake not applied after wait time");

  // the single-tube floor must hold at the moment of release, not only in the mux
  tube_release_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) // RL6
    $rose(O_BRAKE_RELEASE) && $past(ctrl_q[hbs_pkg::CTRL_SINGLE_TUBE_BIT]) &&
      $past(release_delay_q) == 16'h0000 |-> $past(ms_cnt_q) >= hbs_pkg::SINGLE_TUBE_MS)
    else $error("single tube release too early");
endmodule : hbs_sequencer

// [logic/hbs_pkg.sv]
package hbs_pkg;
  // register offsets
  localparam logic [7:0] ADDR_RELEASE_DELAY = 8'h0b;
  localparam logic [7:0] ADDR_APPLY_DELAY = 8'h07;
  localparam logic [7:0] ADDR_WAIT_TIME = 8'h09;
  localparam logic [7:0] ADDR_SPEED_THRESH = 8'h0a;
  localparam logic [7:0] ADDR_CTRL = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h21;
  // reset values (ms, rpm)
  localparam logic [15:0] RST_RELEASE_DELAY = 16'h000a;
  localparam logic [15:0] RST_APPLY_DELAY = 16'h0000;
  localparam logic [15:0] RST_WAIT_TIME = 16'h0032;
  localparam logic [15:0] RST_SPEED_THRESH = 16'h0064;
  localparam logic [15:0] MAX_DELAY_MS = 16'h07d0;
  // ctrl fields
  localparam int CTRL_ZS_STOP_BIT = 0;
  localparam int CTRL_SINGLE_TUBE_BIT = 1;
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam logic [15:0] SINGLE_TUBE_MS = 16'h0014;

  typedef enum {
    ST_OFF,
    ST_RELEASE_WAIT,
    ST_RUN,
    ST_ZERO_SPEED,
    ST_STOP_WAIT,
    ST_APPLY_WAIT
  } hbs_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } hbs_bus_s;
endpackage : hbs_pkg

// [tb/hbs_motor_model.sv]
`timescale 1ns/1ps
module hbs_motor_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // drive side
  input wire logic i_energize,
  input wire logic i_release,
  input wire logic [15:0] i_cmd_rpm,
  // speed feedback
  output logic [15:0] o_rpm
);
  // shaft jumps up to a higher command when powered with the brake off, else coasts down
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n) o_rpm <= 16'h0000;
    else if (i_energize && i_release && i_cmd_rpm >= o_rpm) o_rpm <= i_cmd_rpm;
    else if (o_rpm != 16'h0000) o_rpm <= o_rpm - 16'h0001;
  end
endmodule : hbs_motor_model

// [tb/holding_brake_sequencer_test.sv]
`timescale 1ns/1ps
module holding_brake_sequencer_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  hbs_pkg::hbs_bus_s bus = '0;
  logic en = 1'b0;
  logic alarm = 1'b0;
  logic [15:0] cmd = 16'h00c8;
  logic [15:0] rpm;
  logic [15:0] rdata;
  logic ener;
  logic zs;
  logic rel;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  initial forever #5 clk = ~clk;
  hbs_sequencer #(.CYC_PER_MS(10), .MOTOR_MAX_RPM(16'h0100)) DUT (.I_REF_CLK(clk),
    .I_RST_N(rst_n), .I_BUS(bus), .O_RDATA(rdata), .I_SERVO_EN(en), .I_ALARM(alarm),
    .I_MOTOR_RPM(rpm), .O_MOTOR_ENERGIZE(ener), .O_ZERO_SPEED_CMD(zs), .O_BRAKE_RELEASE(rel));
  hbs_motor_model motor (.i_clk(clk), .i_rst_n(rst_n), .i_energize(ener), .i_release(rel),
    .i_cmd_rpm(cmd), .o_rpm(rpm));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    chk("rdata", rdata, exp);
  endtask : rd
  task automatic se(input logic v, input logic [15:0] c);
    @(posedge clk);
    en <= v;
    cmd <= c;
  endtask : se
  // hang guard, the whole run needs about 660 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      summarize();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(hbs_pkg::ADDR_RELEASE_DELAY, hbs_pkg::RST_RELEASE_DELAY);
    rd(8'h55, 16'h0000);
    wr(hbs_pkg::ADDR_RELEASE_DELAY, 16'h0bb8);
    rd(hbs_pkg::ADDR_RELEASE_DELAY, hbs_pkg::MAX_DELAY_MS);
    wr(hbs_pkg::ADDR_RELEASE_DELAY, 16'h0002);
    $display("test registers done");
    se(1'b1, 16'h00c8);
    wt(2);
    chk("energize", ener, 1'b1);
    wt(13);
    chk("brake early", rel, 1'b0);
    wt(10);
    chk("brake late", rel, 1'b1);
    se(1'b0, 16'h0000);
    wt(20);
    chk("brake turning", rel, 1'b1);
    wt(100);
    chk("brake slow", rel, 1'b0);
    chk("energize off", ener, 1'b0);
    $display("test enable and slow stop done");
    wr(hbs_pkg::ADDR_SPEED_THRESH, 16'hffff);
    wr(hbs_pkg::ADDR_WAIT_TIME, 16'h0003);
    se(1'b1, 16'h012c);
    wt(40);
    se(1'b0, 16'h012c);
    wt(5);
    chk("threshold clamp", rel, 1'b1);
    wt(35);
    chk("brake timeout", rel, 1'b0);
    chk("still fast", rpm > 16'h0100, 1'b1);
    $display("test clamp and timeout done");
    wr(hbs_pkg::ADDR_CTRL, 16'h0002);
    wr(hbs_pkg::ADDR_RELEASE_DELAY, 16'h0000);
    wr(hbs_pkg::ADDR_SPEED_THRESH, 16'h0064);
    se(1'b1, 16'h00c8);
    wt(150);
    chk("tube early", rel, 1'b0);
    wt(100);
    chk("tube late", rel, 1'b1);
    $display("test single tube done");
    wr(hbs_pkg::ADDR_CTRL, 16'h0001);
    @(posedge clk);
    alarm <= 1'b1;
    wt(2);
    chk("zero speed", zs, 1'b1);
    chk("alarm brake", rel, 1'b0);
    wt(150);
    chk("zero speed end", zs, 1'b0);
    chk("alarm energize", ener, 1'b0);
    $display("test alarm stop done");
    summarize();
  end
endmodule : holding_brake_sequencer_test
